// [hw/aux_pin_i2c_master.sv]
// Purpose: register driven i2c master on two auxiliary pins
// Assumes: wishbone on clk, serial engine on link_clk, open-drain pins
// Notes:   parameters of a transfer are frozen while it runs
//
// The Wishbone register port is this design's own decision.

`timescale 1ns/1ps

module aux_pin_i2c_master (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        link_clk,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [11:0] wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	input  wire logic [3:0]  aux_pin_in,
	output logic      [3:0]  aux_pin_out,
	output logic      [3:0]  aux_pin_oe
);

	aux_i2c_pkg::bus_state_type  b_reg;
	aux_i2c_pkg::bus_state_type  b_next;
	aux_i2c_pkg::link_state_type l_reg;
	aux_i2c_pkg::link_state_type l_next;

	logic       bus_hit;
	logic       bus_wr;
	logic       zero_wr;
	logic [7:0] reg_idx;
	logic       done_evt;
	logic       cfg_ok;
	logic       launch_wr;
	logic       tick;
	logic       link_en;
	logic [1:0] i2c_low;
	logic [3:0] port_oe;
	logic [3:0] port_out;

	function automatic logic [15:0] merge(input logic [15:0] old);
		merge = {wb_sel[1] ? wb_dat_w[15:8] : old[15:8],
			wb_sel[0] ? wb_dat_w[7:0] : old[7:0]};
	endfunction : merge

	// words are stable while busy, so the link side may read them directly
	function automatic logic [7:0] frame_byte(input logic [2:0] idx);
		case (idx)
			3'h0: frame_byte = b_reg.launch[7:0];
			3'h1: frame_byte = b_reg.pointer[15:8];
			3'h2: frame_byte = b_reg.pointer[7:0];
			3'h3: frame_byte = b_reg.wdata_up[15:8];
			3'h4: frame_byte = b_reg.wdata_up[7:0];
			3'h5: frame_byte = b_reg.wdata_lo[15:8];
			default: frame_byte = b_reg.wdata_lo[7:0];
		endcase
	endfunction : frame_byte

	assign bus_hit   = wb_cyc && wb_stb && !b_reg.ack;
	assign bus_wr    = bus_hit && wb_we && wb_adr[11:10] == 2'h0;
	assign reg_idx   = wb_adr[9:2];
	assign zero_wr   = bus_wr && wb_sel[1:0] == 2'h3
		&& wb_dat_w[15:0] == aux_i2c_pkg::ZERO_WORD;
	assign done_evt  = b_reg.done_s2 != b_reg.done_prev;
	assign cfg_ok    = b_reg.config_word[15:aux_i2c_pkg::CFG_MODE_LSB]
		== aux_i2c_pkg::CFG_SIMPLE_WRITE
		&& b_reg.pin_ctrl[aux_i2c_pkg::CTRL_EN_BIT];
	assign launch_wr = bus_wr && reg_idx == aux_i2c_pkg::IDX_LAUNCH
		&& !b_reg.busy;

	assign wb_ack      = b_reg.ack;
	assign wb_dat_r    = b_reg.rdata;
	assign aux_pin_out = l_reg.pin_out;
	assign aux_pin_oe  = l_reg.pin_oe;

	// bus domain
	always_comb begin
		b_next = b_reg;
		b_next.ack = bus_hit;
		b_next.pin_s1 = aux_pin_in;
		b_next.pin_s2 = b_reg.pin_s1;
		b_next.done_s1 = l_reg.done_tog;
		b_next.done_s2 = b_reg.done_s1;
		b_next.done_prev = b_reg.done_s2;
		b_next.rdata = '0;
		if (bus_hit && !wb_we && wb_adr[11:10] == 2'h0) begin
			case (reg_idx)
				aux_i2c_pkg::IDX_ALERT: b_next.rdata[15:0] = b_reg.alert;
				aux_i2c_pkg::IDX_POINTER: b_next.rdata[15:0] = b_reg.pointer;
				aux_i2c_pkg::IDX_WDATA_UP: b_next.rdata[15:0] = b_reg.wdata_up;
				aux_i2c_pkg::IDX_WDATA_LO: b_next.rdata[15:0] = b_reg.wdata_lo;
				aux_i2c_pkg::IDX_CONFIG: b_next.rdata[15:0] = b_reg.config_word;
				aux_i2c_pkg::IDX_RESULT: b_next.rdata[15:0] = b_reg.result;
				aux_i2c_pkg::IDX_LAUNCH: b_next.rdata[15:0] = b_reg.launch;
				aux_i2c_pkg::IDX_PIN_CTRL: b_next.rdata[15:0] = b_reg.pin_ctrl;
				aux_i2c_pkg::IDX_PIN_READ: b_next.rdata[3:0] = b_reg.pin_s2;
				default: b_next.rdata = '0;
			endcase
		end
		if (bus_wr && !b_reg.busy) begin
			case (reg_idx)
				aux_i2c_pkg::IDX_POINTER:
					b_next.pointer = merge(b_reg.pointer);
				aux_i2c_pkg::IDX_WDATA_UP: b_next.wdata_up = merge(b_reg.wdata_up);
				aux_i2c_pkg::IDX_WDATA_LO: b_next.wdata_lo = merge(b_reg.wdata_lo);
				aux_i2c_pkg::IDX_CONFIG: b_next.config_word = merge(b_reg.config_word);
				default: b_next.pointer = b_reg.pointer;
			endcase
		end
		if (bus_wr && reg_idx == aux_i2c_pkg::IDX_PIN_CTRL) begin
			b_next.pin_ctrl = merge(b_reg.pin_ctrl);
		end
		if (zero_wr && reg_idx == aux_i2c_pkg::IDX_ALERT) begin
			b_next.alert = '0;
		end
		if (zero_wr && reg_idx == aux_i2c_pkg::IDX_RESULT) begin
			b_next.result = '0;
		end
		if (launch_wr) begin
			b_next.launch = merge(b_reg.launch);
			if (cfg_ok) begin
				b_next.busy = 1'b1;
				b_next.req_tog = !b_reg.req_tog;
				b_next.result = aux_i2c_pkg::RESULT_RUNNING;
			end else begin
				b_next.result[aux_i2c_pkg::RES_DONE] = 1'b1;
				b_next.result[aux_i2c_pkg::RES_REJECT] = 1'b1;
				b_next.alert[aux_i2c_pkg::ALERT_ERR] = 1'b1;
			end
		end
		// completion sets after any clear, so a same-cycle event survives
		if (done_evt) begin
			b_next.busy = 1'b0;
			b_next.result[aux_i2c_pkg::RES_BUSY] = 1'b0;
			b_next.result[aux_i2c_pkg::RES_DONE] = 1'b1;
			b_next.result[aux_i2c_pkg::RES_OK] = !l_reg.nack;
			b_next.result[aux_i2c_pkg::RES_NACK] = l_reg.nack;
			b_next.alert[aux_i2c_pkg::ALERT_DONE] = 1'b1;
			if (l_reg.nack) begin
				b_next.alert[aux_i2c_pkg::ALERT_ERR] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			b_reg <= '0;
		end else begin
			b_reg <= b_next;
		end
	end

	// per-port pin steering
	assign link_en = l_reg.ctrl_s2[aux_i2c_pkg::CTRL_EN_BIT];
	assign i2c_low = {l_reg.scl_low, l_reg.sda_low};

	for (genvar i = 0; i < aux_i2c_pkg::AUX_PORTS; i++) begin : g_port
		aux_i2c_pkg::aux_mode_type mode;
		logic                      drive;
		assign mode = aux_i2c_pkg::aux_mode_type'(l_reg.ctrl_s2[2*i+1:2*i]);
		assign drive = l_reg.ctrl_s2[aux_i2c_pkg::CTRL_DRIVE_LSB + i];
		if (i < 2) begin : g_shared
			// i2c mode: pull low only, release for high; gpio output drives the drive bit
			assign port_oe[i] = link_en ? i2c_low[i]
				: mode == aux_i2c_pkg::AUX_GPIO_OUT;
			assign port_out[i] = !link_en && drive;
		end else begin : g_plain
			// analog modes leave the pin released
			assign port_oe[i] = mode == aux_i2c_pkg::AUX_GPIO_OUT;
			assign port_out[i] = drive;
		end
	end

	// link domain: serial engine
	assign tick = l_reg.quarter == 5'h00;

	always_comb begin
		l_next = l_reg;
		l_next.rst_s1 = reset;
		l_next.rst_s2 = l_reg.rst_s1;
		l_next.ctrl_s1 = b_reg.pin_ctrl;
		l_next.ctrl_s2 = l_reg.ctrl_s1;
		l_next.req_s1 = b_reg.req_tog;
		l_next.req_s2 = l_reg.req_s1;
		l_next.req_prev = l_reg.req_s2;
		l_next.sda_s1 = aux_pin_in[0];
		l_next.sda_s2 = l_reg.sda_s1;
		l_next.pin_oe = port_oe;
		l_next.pin_out = port_out;
		if (l_reg.state != aux_i2c_pkg::I_IDLE) begin
			if (tick) begin
				l_next.quarter = aux_i2c_pkg::QUARTER_CYC - 5'h01;
				l_next.phase = l_reg.phase + 2'h1;
			end else begin
				l_next.quarter = l_reg.quarter - 5'h01;
			end
		end
		unique case (l_reg.state)
			aux_i2c_pkg::I_IDLE: begin
				l_next.sda_low = 1'b0;
				l_next.scl_low = 1'b0;
				if (l_reg.req_s2 != l_reg.req_prev) begin
					l_next.state = aux_i2c_pkg::I_START;
					l_next.quarter = aux_i2c_pkg::QUARTER_CYC - 5'h01;
					l_next.phase = 2'h0;
					l_next.byte_idx = 3'h0;
					l_next.bit_cnt = 3'h0;
					l_next.nack = 1'b0;
					l_next.shift = frame_byte(3'h0);
				end
			end
			aux_i2c_pkg::I_START: begin
				l_next.sda_low = l_reg.phase != 2'h0;
				l_next.scl_low = l_reg.phase[1];
				if (tick && l_reg.phase == 2'h3) begin
					l_next.state = aux_i2c_pkg::I_BIT;
				end
			end
			aux_i2c_pkg::I_BIT: begin
				l_next.sda_low = !l_reg.shift[7];
				l_next.scl_low = l_reg.phase == 2'h0 || l_reg.phase == 2'h3;
				if (tick && l_reg.phase == 2'h3) begin
					l_next.shift = {l_reg.shift[6:0], 1'b0};
					l_next.bit_cnt = l_reg.bit_cnt + 3'h1;
					if (l_reg.bit_cnt == aux_i2c_pkg::BIT_LAST) begin
						l_next.state = aux_i2c_pkg::I_ACK;
					end
				end
			end
			aux_i2c_pkg::I_ACK: begin
				l_next.sda_low = 1'b0;
				l_next.scl_low = l_reg.phase == 2'h0 || l_reg.phase == 2'h3;
				if (tick && l_reg.phase == 2'h2) begin
					l_next.nack = l_reg.sda_s2;
				end
				if (tick && l_reg.phase == 2'h3) begin
					if (l_reg.nack || l_reg.byte_idx == aux_i2c_pkg::LAST_BYTE) begin
						l_next.state = aux_i2c_pkg::I_STOP;
					end else begin
						l_next.byte_idx = l_reg.byte_idx + 3'h1;
						l_next.shift = frame_byte(l_reg.byte_idx + 3'h1);
						l_next.state = aux_i2c_pkg::I_BIT;
					end
				end
			end
			aux_i2c_pkg::I_STOP: begin
				l_next.sda_low = !l_reg.phase[1];
				l_next.scl_low = l_reg.phase == 2'h0;
				if (tick && l_reg.phase == 2'h3) begin
					l_next.state = aux_i2c_pkg::I_DONE;
				end
			end
			aux_i2c_pkg::I_DONE: begin
				l_next.done_tog = !l_reg.done_tog;
				l_next.state = aux_i2c_pkg::I_IDLE;
			end
			default: begin
				l_next.state = aux_i2c_pkg::I_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk) begin
		if (l_reg.rst_s2) begin
			l_reg <= '0;
			l_reg.rst_s1 <= reset;
			l_reg.rst_s2 <= l_reg.rst_s1;
		end else begin
			l_reg <= l_next;
		end
	end

	idle_release_a: assert property (
		@(posedge link_clk) disable iff (l_reg.rst_s2)
		(link_en && l_reg.state == aux_i2c_pkg::I_IDLE) [*3]
		|-> aux_pin_oe[1:0] == 2'h0)
		else $error("idle bus lines not released");

	pins_shared_a: assert property (
		@(posedge link_clk) disable iff (l_reg.rst_s2)
		link_en [*2] |-> aux_pin_oe[1] == $past(l_reg.scl_low)
			&& aux_pin_out[1:0] == 2'h0)
		else $error("clock pin not driven by the engine");

	word_order_a: assert property (
		@(posedge link_clk) disable iff (l_reg.rst_s2)
		l_reg.state == aux_i2c_pkg::I_BIT && l_reg.bit_cnt == 3'h0
			&& l_reg.byte_idx == 3'h3
		|-> l_reg.shift == b_reg.wdata_up[15:8])
		else $error("upper data word not sent first");

	status_clear_a: assert property (
		@(posedge clk) disable iff (reset)
		zero_wr && reg_idx == aux_i2c_pkg::IDX_ALERT && !done_evt
			&& !launch_wr |=> b_reg.alert == aux_i2c_pkg::ZERO_WORD)
		else $error("alert status not cleared by zero write");

	pointer_load_a: assert property (
		@(posedge clk) disable iff (reset)
		bus_wr && reg_idx == aux_i2c_pkg::IDX_POINTER && !b_reg.busy
			&& wb_sel[1:0] == 2'h3
		|=> b_reg.pointer == $past(wb_dat_w[15:0]))
		else $error("target pointer not loaded");

	mode_reject_a: assert property (
		@(posedge clk) disable iff (reset)
		launch_wr && !cfg_ok
		|=> !b_reg.busy && b_reg.result[aux_i2c_pkg::RES_REJECT])
		else $error("launch without simple write not rejected");

	result_clear_a: assert property (
		@(posedge clk) disable iff (reset)
		zero_wr && reg_idx == aux_i2c_pkg::IDX_RESULT && !done_evt
		|=> b_reg.result == aux_i2c_pkg::ZERO_WORD)
		else $error("result not cleared by zero write");

	launch_start_a: assert property (
		@(posedge clk) disable iff (reset)
		launch_wr && cfg_ok
		|=> b_reg.busy && b_reg.req_tog != $past(b_reg.req_tog))
		else $error("launch did not start a transfer");

	done_ok_a: assert property (
		@(posedge clk) disable iff (reset)
		done_evt && !l_reg.nack
			&& b_reg.result == aux_i2c_pkg::RESULT_RUNNING
		|=> b_reg.result == aux_i2c_pkg::RESULT_SUCCESS && !b_reg.busy)
		else $error("clean completion not reported as success");

	busy_guard_a: assert property (
		@(posedge clk) disable iff (reset)
		b_reg.busy && !done_evt
		|=> !b_reg.result[aux_i2c_pkg::RES_DONE]
			&& $stable(b_reg.launch) && $stable(b_reg.pointer))
		else $error("running transfer disturbed or reported done");

	start_seen_a: assert property (
		@(posedge link_clk) disable iff (l_reg.rst_s2)
		l_reg.state == aux_i2c_pkg::I_IDLE
			&& l_reg.req_s2 != l_reg.req_prev
		|=> l_reg.state == aux_i2c_pkg::I_START)
		else $error("launch request not picked up by the engine");

	analog_release_a: assert property (
		@(posedge link_clk) disable iff (l_reg.rst_s2)
		l_reg.ctrl_s2[5:4] != aux_i2c_pkg::AUX_GPIO_OUT
		|=> !aux_pin_oe[2])
		else $error("port two driven outside gpio output mode");

	reject_alert_a: assert property (
		@(posedge clk) disable iff (reset)
		launch_wr && !cfg_ok
		|=> b_reg.alert[aux_i2c_pkg::ALERT_ERR])
		else $error("rejected launch not flagged in alert status");

	run_result_a: assert property (
		@(posedge clk) disable iff (reset)
		launch_wr && cfg_ok
		|=> b_reg.result == aux_i2c_pkg::RESULT_RUNNING)
		else $error("started transfer not shown as running");

	launch_ignored_a: assert property (
		@(posedge clk) disable iff (reset)
		b_reg.busy && !done_evt && bus_wr
			&& reg_idx == aux_i2c_pkg::IDX_LAUNCH
		|=> $stable(b_reg.req_tog) && b_reg.busy)
		else $error("launch while busy disturbed the transfer");

endmodule : aux_pin_i2c_master

// [hw/aux_i2c_pkg.sv]
// Purpose: constants and types for the auxiliary-pin i2c master
// Assumes: 32-bit classic wishbone, register word index = byte address / 4
// Notes:   link domain runs the serial engine on its own clock

package aux_i2c_pkg;

	localparam int         ADR_W        = 12;
	localparam int         DAT_W        = 32;

	// register word indices
	localparam logic [7:0] IDX_ALERT    = 8'h02;
	localparam logic [7:0] IDX_POINTER  = 8'h84;
	localparam logic [7:0] IDX_WDATA_UP = 8'h85;
	localparam logic [7:0] IDX_WDATA_LO = 8'h86;
	localparam logic [7:0] IDX_CONFIG   = 8'h89;
	localparam logic [7:0] IDX_RESULT   = 8'h8a;
	localparam logic [7:0] IDX_LAUNCH   = 8'h8b;
	localparam logic [7:0] IDX_PIN_CTRL = 8'h18;
	localparam logic [7:0] IDX_PIN_READ = 8'h19;

	// pin control fields
	localparam int         CTRL_EN_BIT    = 15;
	localparam int         CTRL_DRIVE_LSB = 8;
	localparam int         AUX_PORTS      = 4;

	// config and result fields
	localparam int         CFG_MODE_LSB     = 13;
	localparam logic [2:0] CFG_SIMPLE_WRITE = 3'h1;
	localparam int         RES_DONE   = 15;
	localparam int         RES_OK     = 14;
	localparam int         RES_NACK   = 13;
	localparam int         RES_REJECT = 12;
	localparam int         RES_BUSY   = 0;
	localparam logic [15:0] RESULT_SUCCESS = 16'hc000;
	localparam logic [15:0] RESULT_RUNNING = 16'h0001;
	localparam logic [15:0] ZERO_WORD      = 16'h0000;
	localparam int         ALERT_DONE = 0;
	localparam int         ALERT_ERR  = 1;

	// frame: address byte, pointer hi/lo, upper word hi/lo, lower word hi/lo
	localparam logic [2:0] LAST_BYTE = 3'h6;
	localparam logic [2:0] BIT_LAST  = 3'h7;

	// serial timing on the link clock
	localparam int         LINK_PERIOD_NS = 125;
	localparam int         SCL_QUARTER_NS = 625;
	localparam logic [4:0] QUARTER_CYC    = 5'((SCL_QUARTER_NS
		+ LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

	typedef enum logic [1:0] {
		AUX_GPIO_IN  = 2'h0,
		AUX_GPIO_OUT = 2'h1,
		AUX_RATIO    = 2'h2,
		AUX_ABS      = 2'h3
	} aux_mode_type;

	typedef enum logic [2:0] {
		I_IDLE  = 3'h0,
		I_START = 3'h1,
		I_BIT   = 3'h2,
		I_ACK   = 3'h3,
		I_STOP  = 3'h4,
		I_DONE  = 3'h5
	} i2c_state_type;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [15:0] alert;
		logic [15:0] pointer;
		logic [15:0] wdata_up;
		logic [15:0] wdata_lo;
		logic [15:0] config_word;
		logic [15:0] result;
		logic [15:0] launch;
		logic [15:0] pin_ctrl;
		logic        busy;
		logic        req_tog;
		logic        done_s1;
		logic        done_s2;
		logic        done_prev;
		logic [3:0]  pin_s1;
		logic [3:0]  pin_s2;
	} bus_state_type;

	typedef struct packed {
		logic          rst_s1;
		logic          rst_s2;
		logic [15:0]   ctrl_s1;
		logic [15:0]   ctrl_s2;
		logic          req_s1;
		logic          req_s2;
		logic          req_prev;
		i2c_state_type state;
		logic [4:0]    quarter;
		logic [1:0]    phase;
		logic [2:0]    bit_cnt;
		logic [2:0]    byte_idx;
		logic [7:0]    shift;
		logic          sda_s1;
		logic          sda_s2;
		logic          nack;
		logic          done_tog;
		logic          sda_low;
		logic          scl_low;
		logic [3:0]    pin_out;
		logic [3:0]    pin_oe;
	} link_state_type;

endpackage : aux_i2c_pkg

// [tb/i2c_target_model.sv]
// Purpose: behavioural i2c target on the far side of the aux pins
// Assumes: open-drain lines with pull-ups; the target never stretches scl
// Notes:   collects each byte of a frame and acks or nacks all of them

`timescale 1ns/1ps

module i2c_target_model (
	input  wire logic   scl,
	input  wire logic   sda,
	input  wire logic   nack_all,
	output logic        sda_low,
	output logic [55:0] frame,
	output logic [3:0]  n_bytes
);
	logic [7:0]  shift_byte = 8'h00;
	logic        active = 1'b0;
	logic        scl_d = 1'b1;
	logic        sda_d = 1'b1;
	logic        low_q = 1'b0;
	logic [55:0] frame_q = '0;
	logic [3:0]  count_q = 4'h0;
	int          bits = 0;

	assign sda_low = low_q;
	assign frame = frame_q;
	assign n_bytes = count_q;

	// one process keeps every variable single-driven
	always @(scl or sda) begin
		if (scl === 1'b1 && scl_d === 1'b1 && sda !== sda_d) begin
			// start and stop are data edges while the clock is high
			active = (sda === 1'b0);
			if (sda === 1'b0) begin
				bits = 0;
				count_q = 4'h0;
				frame_q = '0;
			end
		end else if (scl === 1'b1 && scl_d !== 1'b1) begin
			if (active && bits < 8) begin
				shift_byte = {shift_byte[6:0], sda};
				bits++;
			end
		end else if (scl !== 1'b1 && scl_d === 1'b1) begin
			// ack slot: data low from the eighth falling clock to the ninth
			if (active && bits == 8) begin
				frame_q = {frame_q[47:0], shift_byte};
				count_q = count_q + 4'h1;
				low_q = !nack_all;
				bits = 9;
			end else if (bits == 9) begin
				low_q = 1'b0;
				bits = 0;
			end
		end
		scl_d = scl;
		sda_d = sda;
	end
endmodule : i2c_target_model

// [tb/test_aux_pin_i2c_master.sv]
// Purpose: self-checking bench for the aux-pin i2c master
// Assumes: pull-ups on all aux pins, target model on ports zero and one
// Notes:   a full frame at the 400 kHz serial rate is a long wait

`timescale 1ns/1ps

module test_aux_pin_i2c_master;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        link_clk = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [11:0] wb_adr = '0;
	logic [3:0]  wb_sel = '0;
	logic [31:0] wb_dat_w = '0;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic [3:0]  pin_in;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic        nack_all = 1'b0;
	logic        tgt_low;
	logic [55:0] frame;
	logic [3:0]  n_bytes;
	logic [15:0] rd;
	int          fail_count = 0;
	int          n_checks = 0;

	always #2.5 clk = ~clk;
	initial begin
		#13.3;
		forever #62.5 link_clk = ~link_clk;
	end

	// ports zero and one open-drain with pull-ups, two and three push-pull; the target only pulls data low
	assign pin_in[0] = !((pin_oe[0] === 1'b1 && pin_out[0] === 1'b0)
		|| tgt_low);
	assign pin_in[1] = !(pin_oe[1] === 1'b1 && pin_out[1] === 1'b0);
	assign pin_in[2] = (pin_oe[2] === 1'b1) ? pin_out[2] : 1'b1;
	assign pin_in[3] = (pin_oe[3] === 1'b1) ? pin_out[3] : 1'b1;

	aux_pin_i2c_master DUT (.clk(clk), .reset(reset), .link_clk(link_clk),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
		.aux_pin_oe(pin_oe));

	i2c_target_model target (.scl(pin_in[1]), .sda(pin_in[0]),
		.nack_all(nack_all), .sda_low(tgt_low), .frame(frame),
		.n_bytes(n_bytes));

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wb(input logic we, input logic [7:0] idx,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {2'b00, idx, 2'b00};
		wb_sel <= 4'hf;
		wb_dat_w <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_dat_r[15:0];
		if (wb_ack !== 1'b1) begin
			fail_count++;
			test_done();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, idx, d, q);
	endtask : wr

	task automatic rdchk(input string name, input logic [7:0] idx,
		input logic [15:0] exp);
		logic [15:0] q;
		wb(1'b0, idx, 16'h0000, q);
		check(name, q, exp);
	endtask : rdchk

	task automatic wait_idle;
		int n;
		n = 0;
		rd = 16'h0001;
		while (rd[0] !== 1'b0 && n < 30000) begin
			wb(1'b0, 8'h8a, 16'h0000, rd);
			n++;
		end
		if (n == 30000) begin
			fail_count++;
			test_done();
		end
	endtask : wait_idle

	task automatic test_reset;
		logic [7:0] regs [7] = '{8'h02, 8'h84, 8'h85, 8'h86, 8'h89,
			8'h8a, 8'h8b};
		foreach (regs[i])
			rdchk("reset value", regs[i], 16'h0000);
		check("reset oe", {12'h000, pin_oe}, 16'h0000);
		wr(8'h40, 16'hffff);
		rdchk("unmapped", 8'h40, 16'h0000);
		$display("test reset done");
	endtask : test_reset

	task automatic test_pins;
		wr(8'h18, 16'h0105);
		repeat (300) @(posedge clk);
		check("drive oe", {12'h000, pin_oe}, 16'h0003);
		check("drive out", {12'h000, pin_out & pin_oe}, 16'h0001);
		rdchk("drive read", 8'h19, 16'h000d);
		wr(8'h18, 16'h8455);
		repeat (300) @(posedge clk);
		check("gpio oe", {12'h000, pin_oe}, 16'h000c);
		check("gpio out", {12'h000, pin_out & pin_oe}, 16'h0004);
		rdchk("gpio read", 8'h19, 16'h0007);
		wr(8'h18, 16'h80e5);
		repeat (300) @(posedge clk);
		check("analog oe", {12'h000, pin_oe}, 16'h0000);
		rdchk("analog read", 8'h19, 16'h000f);
		$display("test pins done");
	endtask : test_pins

	task automatic test_write;
		wr(8'h02, 16'h0000);
		wr(8'h84, 16'h0004);
		wr(8'h85, 16'haa55);
		wr(8'h86, 16'h9669);
		wr(8'h89, 16'h2000);
		wr(8'h8a, 16'h0000);
		wr(8'h8b, 16'h78a8);
		rdchk("result busy", 8'h8a, 16'h0001);
		wr(8'h8b, 16'h00ff);
		wr(8'h84, 16'h1234);
		rdchk("pointer held", 8'h84, 16'h0004);
		wait_idle();
		check("result", rd, 16'hc000);
		check("bytes", {12'h000, n_bytes}, 16'h0007);
		check("addr byte", {8'h00, frame[55:48]}, 16'h00a8);
		check("pointer", frame[47:32], 16'h0004);
		check("upper", frame[31:16], 16'haa55);
		check("lower", frame[15:0], 16'h9669);
		repeat (2000) @(posedge clk);
		rdchk("no relaunch", 8'h8a, 16'hc000);
		check("idle oe", {12'h000, pin_oe}, 16'h0000);
		rdchk("alert done", 8'h02, 16'h0001);
		wr(8'h02, 16'h0000);
		rdchk("alert clear", 8'h02, 16'h0000);
		wr(8'h8a, 16'h0000);
		rdchk("result clear", 8'h8a, 16'h0000);
		$display("test write done");
	endtask : test_write

	task automatic test_errors;
		wr(8'h89, 16'h0000);
		wr(8'h8b, 16'h00a8);
		rdchk("reject", 8'h8a, 16'h9000);
		wr(8'h8a, 16'h0000);
		rdchk("reject clear", 8'h8a, 16'h0000);
		wr(8'h02, 16'h0000);
		wr(8'h89, 16'h2000);
		nack_all <= 1'b1;
		wr(8'h8b, 16'h00a8);
		wait_idle();
		check("nack result", rd, 16'ha000);
		check("nack bytes", {12'h000, n_bytes}, 16'h0001);
		rdchk("nack alert", 8'h02, 16'h0003);
		nack_all <= 1'b0;
		$display("test errors done");
	endtask : test_errors

	initial begin
		repeat (20) @(posedge link_clk);
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		test_reset();
		test_pins();
		test_write();
		test_errors();
		test_done();
	end
endmodule : test_aux_pin_i2c_master
